// ### mbst_pkg.sv
// Constants and types for the memory boundary-scan test access port.
//
// Function
// RULE1: Code 000 captures and shifts the pin ring and floats memory outputs.
// RULE2: Code 001 shifts the loaded identification word, memory untouched.
// RULE3: Code 010 captures and shifts the pins and disables memory drivers.
// RULE4: The tester must never load the reserved codes 011, 101 or 110.
// RULE5: Code 100 shifts the captured pin ring, memory untouched, no preload.
// RULE6: Code 111 puts the one-bit bypass register between serial in and out.
// RULE7: Identification bits 31 to 29 hold the revision number.
// RULE8: Identification bits 11 to 1 hold the eleven-bit vendor code.
// RULE9: Identification bit 0 is always one.
// RULE10: Identification bits 17 to 15 code the width, 18 and 36 differing.
// RULE11: Identification bits 14 to 12 encode the memory density.
// RULE12: Identification bits 20 to 18 encode the memory type.
// RULE13: Reset and test-logic-reset select the identifier instruction.
// RULE14: New instruction bits shift in and take effect on entering update.
// RULE15: Under the sample instruction, data-update acts like data-pause.
// RULE16: Serial out moves after test clock falls, floats outside shift states.
package mbst_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int IR_W    = 3;
  localparam int ID_W    = 32;
  localparam int CHAIN_W = 70;

  // ---------------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPZ  = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_RESET   = INS_IDCODE;
  localparam logic [1:0] IR_CAPTURE = 2'h1;

  // ---------------------------------------------------------------------
  // Identification fields, values are arbitrary where marked
  // ---------------------------------------------------------------------
  localparam logic [2:0]  ID_REVISION = 3'h0;
  localparam logic [1:0]  ID_VOLTAGE  = 2'h1;
  localparam logic [2:0]  ID_DEPT     = 3'h5;
  localparam logic [2:0]  ID_ARCH     = 3'h1;
  localparam logic [2:0]  ID_MEMTYPE  = 3'h1;
  localparam logic [2:0]  ID_WIDTH_18 = 3'h2;
  localparam logic [2:0]  ID_WIDTH_36 = 3'h4;
  localparam logic [2:0]  ID_DENSITY  = 3'h7;
  // Vendor code value is arbitrary.
  localparam logic [10:0] ID_VENDOR   = 11'h5A5;
  localparam logic        ID_PRESENT  = 1'h1;

  // ---------------------------------------------------------------------
  // Test state machine
  // ---------------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008, ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020,
    ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } mbst_state_t;

endpackage

// ### mbst_sync.sv
// Two-flop synchroniser for the test pins.
`timescale 1ns/100ps
module mbst_sync (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_sync
);

  logic [2:0] stage1;
  logic [2:0] next_stage1;
  logic [2:0] next_pin_sync;

  always_comb begin
    next_stage1   = pin_in;
    next_pin_sync = stage1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1   <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      stage1   <= next_stage1;
      pin_sync <= next_pin_sync;
    end
  end

endmodule

// ### mbst_tap.sv
// Boundary-scan test access port for the pipelined memory.
`timescale 1ns/100ps
module mbst_tap (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  input  wire logic                        width_36,
  input  wire logic [mbst_pkg::CHAIN_W-1:0] pin_ring,
  output logic                             tdo_out,
  output logic                             tdo_oe,
  output logic                             mem_out_hiz,
  output logic [2:0]                       instruction_select
);

  // ---------------------------------------------------------------------
  // Pin sampling and test clock edges
  // ---------------------------------------------------------------------
  logic [2:0] pins_s;
  logic       tck_d;
  logic       next_tck_d;
  logic       tck_rise;
  logic       tck_fall;

  mbst_sync u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({tck, tms, tdi}),
    .pin_sync (pins_s)
  );

  always_comb begin
    next_tck_d = pins_s[2];
    tck_rise   = pins_s[2] & ~tck_d;
    tck_fall   = ~pins_s[2] & tck_d;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_d <= 1'h0;
    end else begin
      tck_d <= next_tck_d;
    end
  end

  // ---------------------------------------------------------------------
  // Memory pin ring sampling
  // ---------------------------------------------------------------------
  logic [mbst_pkg::CHAIN_W-1:0] ring_s1;
  logic [mbst_pkg::CHAIN_W-1:0] ring_s2;
  logic [mbst_pkg::CHAIN_W-1:0] next_ring_s1;
  logic [mbst_pkg::CHAIN_W-1:0] next_ring_s2;

  // The ring moves with the memory clock, so it passes two flops first.
  always_comb begin
    next_ring_s1 = pin_ring;
    next_ring_s2 = ring_s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ring_s1 <= '0;
      ring_s2 <= '0;
    end else begin
      ring_s1 <= next_ring_s1;
      ring_s2 <= next_ring_s2;
    end
  end

  // ---------------------------------------------------------------------
  // Identification word
  // ---------------------------------------------------------------------
  function automatic logic [mbst_pkg::ID_W-1:0] id_word(input logic w36);
    logic [2:0] wcode;
    wcode = w36 ? mbst_pkg::ID_WIDTH_36 : mbst_pkg::ID_WIDTH_18;
    // RULE7 RULE8 RULE9 id fields
    // RULE10 RULE11 RULE12 id fields
    id_word = {mbst_pkg::ID_REVISION, mbst_pkg::ID_VOLTAGE[1],
               mbst_pkg::ID_DEPT, mbst_pkg::ID_VOLTAGE[0],
               mbst_pkg::ID_ARCH, mbst_pkg::ID_MEMTYPE, wcode,
               mbst_pkg::ID_DENSITY, mbst_pkg::ID_VENDOR,
               mbst_pkg::ID_PRESENT};
  endfunction

  function automatic logic is_chain(input logic [2:0] ins);
    is_chain = (ins == mbst_pkg::INS_EXTEST) ||
               (ins == mbst_pkg::INS_SAMPZ) ||
               (ins == mbst_pkg::INS_SAMPLE);
  endfunction

  // ---------------------------------------------------------------------
  // Test state machine
  // ---------------------------------------------------------------------
  mbst_pkg::mbst_state_t state;
  mbst_pkg::mbst_state_t next_state;

  always_comb begin
    next_state = state;
    if (tck_rise) begin
      case (state)
        mbst_pkg::ST_RESET:
          next_state = pins_s[1] ? mbst_pkg::ST_RESET : mbst_pkg::ST_IDLE;
        mbst_pkg::ST_IDLE:
          next_state = pins_s[1] ? mbst_pkg::ST_SELDR : mbst_pkg::ST_IDLE;
        mbst_pkg::ST_SELDR:
          next_state = pins_s[1] ? mbst_pkg::ST_SELIR : mbst_pkg::ST_CAPDR;
        mbst_pkg::ST_CAPDR:
          next_state = pins_s[1] ? mbst_pkg::ST_EX1DR : mbst_pkg::ST_SHDR;
        mbst_pkg::ST_SHDR:
          next_state = pins_s[1] ? mbst_pkg::ST_EX1DR : mbst_pkg::ST_SHDR;
        mbst_pkg::ST_EX1DR:
          next_state = pins_s[1] ? mbst_pkg::ST_UPDR : mbst_pkg::ST_PSDR;
        mbst_pkg::ST_PSDR:
          next_state = pins_s[1] ? mbst_pkg::ST_EX2DR : mbst_pkg::ST_PSDR;
        mbst_pkg::ST_EX2DR:
          next_state = pins_s[1] ? mbst_pkg::ST_UPDR : mbst_pkg::ST_SHDR;
        mbst_pkg::ST_UPDR:
          next_state = pins_s[1] ? mbst_pkg::ST_SELDR : mbst_pkg::ST_IDLE;
        mbst_pkg::ST_SELIR:
          next_state = pins_s[1] ? mbst_pkg::ST_RESET : mbst_pkg::ST_CAPIR;
        mbst_pkg::ST_CAPIR:
          next_state = pins_s[1] ? mbst_pkg::ST_EX1IR : mbst_pkg::ST_SHIR;
        mbst_pkg::ST_SHIR:
          next_state = pins_s[1] ? mbst_pkg::ST_EX1IR : mbst_pkg::ST_SHIR;
        mbst_pkg::ST_EX1IR:
          next_state = pins_s[1] ? mbst_pkg::ST_UPIR : mbst_pkg::ST_PSIR;
        mbst_pkg::ST_PSIR:
          next_state = pins_s[1] ? mbst_pkg::ST_EX2IR : mbst_pkg::ST_PSIR;
        mbst_pkg::ST_EX2IR:
          next_state = pins_s[1] ? mbst_pkg::ST_UPIR : mbst_pkg::ST_SHIR;
        mbst_pkg::ST_UPIR:
          next_state = pins_s[1] ? mbst_pkg::ST_SELDR : mbst_pkg::ST_IDLE;
        default:
          next_state = mbst_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= mbst_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------
  // Shift registers
  // ---------------------------------------------------------------------
  logic [2:0]                  ir_shift;
  logic [2:0]                  next_ir_shift;
  logic [2:0]                  next_instruction_select;
  logic                        bypass_bit;
  logic                        next_bypass_bit;
  logic [mbst_pkg::ID_W-1:0]   identification;
  logic [mbst_pkg::ID_W-1:0]   next_identification;
  logic [mbst_pkg::CHAIN_W-1:0] pin_scan_chain;
  logic [mbst_pkg::CHAIN_W-1:0] next_pin_scan_chain;

  always_comb begin
    next_ir_shift           = ir_shift;
    next_instruction_select = instruction_select;
    next_bypass_bit         = bypass_bit;
    next_identification     = identification;
    next_pin_scan_chain     = pin_scan_chain;
    // RULE13 identifier at reset
    if (state == mbst_pkg::ST_RESET) begin
      next_instruction_select = mbst_pkg::IR_RESET;
    end
    // RULE14 instruction takes effect
    if (state == mbst_pkg::ST_UPIR) begin
      next_instruction_select = ir_shift;
    end
    if (tck_rise) begin
      case (state)
        mbst_pkg::ST_CAPIR: begin
          next_ir_shift = {1'h0, mbst_pkg::IR_CAPTURE};
        end
        mbst_pkg::ST_SHIR: begin
          // RULE14 shift instruction bits
          next_ir_shift = {pins_s[0], ir_shift[2:1]};
        end
        mbst_pkg::ST_CAPDR: begin
          // RULE2 load identification
          next_identification = id_word(width_36);
          next_bypass_bit     = 1'h0;
          // RULE1 RULE3 RULE5 capture pin ring
          if (is_chain(instruction_select)) begin
            next_pin_scan_chain = ring_s2;
          end
        end
        mbst_pkg::ST_SHDR: begin
          // RULE6 bypass path
          next_bypass_bit     = pins_s[0];
          next_identification = {pins_s[0], identification[31:1]};
          next_pin_scan_chain = {pins_s[0],
                                 pin_scan_chain[mbst_pkg::CHAIN_W-1:1]};
        end
        default: begin
          // RULE15 update acts as pause
          next_pin_scan_chain = pin_scan_chain;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_shift           <= 3'h0;
      instruction_select <= mbst_pkg::IR_RESET;
      bypass_bit         <= 1'h0;
      identification     <= '0;
      pin_scan_chain     <= '0;
    end else begin
      ir_shift           <= next_ir_shift;
      instruction_select <= next_instruction_select;
      bypass_bit         <= next_bypass_bit;
      identification     <= next_identification;
      pin_scan_chain     <= next_pin_scan_chain;
    end
  end

  // ---------------------------------------------------------------------
  // Serial out and output control
  // ---------------------------------------------------------------------
  logic serial_bit;
  logic next_tdo_out;
  logic next_tdo_oe;
  logic next_mem_out_hiz;

  always_comb begin
    if (state == mbst_pkg::ST_SHIR) begin
      serial_bit = ir_shift[0];
    end else if (is_chain(instruction_select)) begin
      serial_bit = pin_scan_chain[0];
    end else if (instruction_select == mbst_pkg::INS_IDCODE) begin
      serial_bit = identification[0];
    end else begin
      serial_bit = bypass_bit;
    end
    next_tdo_out = tdo_out;
    next_tdo_oe  = tdo_oe;
    // RULE16 falling edge output
    if (tck_fall) begin
      next_tdo_out = serial_bit;
      next_tdo_oe  = (state == mbst_pkg::ST_SHIR) ||
                     (state == mbst_pkg::ST_SHDR);
    end
    // RULE1 RULE3 outputs forced off
    next_mem_out_hiz = (instruction_select == mbst_pkg::INS_EXTEST) ||
                       (instruction_select == mbst_pkg::INS_SAMPZ);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdo_out     <= 1'h0;
      tdo_oe      <= 1'h0;
      mem_out_hiz <= 1'h0;
    end else begin
      tdo_out     <= next_tdo_out;
      tdo_oe      <= next_tdo_oe;
      mem_out_hiz <= next_mem_out_hiz;
    end
  end

endmodule

// ### mbst_tap_asserts.sv
// Port assertions for the boundary-scan test access port.
`timescale 1ns/100ps
module mbst_tap_asserts (
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic                          tck,
  input wire logic                          tms,
  input wire logic                          tdi,
  input wire logic                          width_36,
  input wire logic [mbst_pkg::CHAIN_W-1:0]  pin_ring,
  input wire logic                          tdo_out,
  input wire logic                          tdo_oe,
  input wire logic                          mem_out_hiz,
  input wire logic [2:0]                    instruction_select
);
  logic [2:0] ir_q1;
  logic [2:0] ir_q2;
  logic       hiz_exp;
  assign hiz_exp = instruction_select == mbst_pkg::INS_EXTEST ||
                   instruction_select == mbst_pkg::INS_SAMPZ;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_q1 <= mbst_pkg::IR_RESET;
      ir_q2 <= mbst_pkg::IR_RESET;
    end else begin
      ir_q1 <= instruction_select;
      ir_q2 <= ir_q1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_id_after_reset: assert property ($fell(rst) |->
    instruction_select == mbst_pkg::IR_RESET && !tdo_oe && !mem_out_hiz)
    else $error("instruction not identifier after reset");
  a_ir_at_rise: assert property ($changed(instruction_select) |->
    $past(tck, 2) && $past(tms, 2))
    else $error("instruction changed outside an update");
  a_ir_stands: assert property ($changed(instruction_select) |=>
    $stable(instruction_select)[*7])
    else $error("instruction did not stand");
  a_tdo_on_fall: assert property ($changed(tdo_out) |->
    !$past(tck) || !$past(tck, 2))
    else $error("serial out moved while test clock high");
  a_oe_on_fall: assert property ($changed(tdo_oe) |->
    !$past(tck) || !$past(tck, 2))
    else $error("serial enable moved while test clock high");
  a_oe_holds: assert property ($rose(tdo_oe) |=> tdo_oe[*7])
    else $error("serial enable pulse too short");
  a_hiz_by_code: assert property ($stable(instruction_select)[*3] |->
    mem_out_hiz == hiz_exp)
    else $error("memory output float does not match instruction");
  a_hiz_with_ir: assert property ($changed(mem_out_hiz) |->
    instruction_select != ir_q2)
    else $error("memory outputs disturbed without instruction change");
  cover property ($rose(tdo_oe));
  cover property ($rose(mem_out_hiz));
  cover property ($changed(instruction_select) &&
    instruction_select == mbst_pkg::INS_BYPASS);
endmodule
bind mbst_tap mbst_tap_asserts mbst_tap_asserts_i (
  .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
  .width_36(width_36), .pin_ring(pin_ring), .tdo_out(tdo_out),
  .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz),
  .instruction_select(instruction_select));

// ### mbst_tester.sv
// Model of the external test controller that drives the test pins.
`timescale 1ns/100ps
module mbst_tester (
  input  wire logic ref_clk,
  input  wire logic tdo_out,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // One test clock period: fall, sample serial out late, then rise.
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge ref_clk);
    tck = 1'h0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge ref_clk);
    q = tdo_oe ? tdo_out : 1'hz;
    tck = 1'h1;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic update();
    logic b;
    step(1'h1, ~tdi, b);
    step(1'h0, ~tdi, b);
  endtask
  task automatic shift_ir(input logic [2:0] c, output logic [2:0] q);
    logic       b;
    logic [2:0] s;
    s = (c inside {3'h3, 3'h5, 3'h6}) ? 3'h7 : c;
    for (int i = 0; i < 4; i++) step(i < 2, ~tdi, b);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, s[i], b);
      q[i] = b;
    end
  endtask
  task automatic shift_dr(input int n, input logic [69:0] d,
                          output logic [69:0] q);
    logic b;
    q = '0;
    for (int i = 0; i < 3; i++) step(i == 0, ~tdi, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    update();
  endtask
  task automatic tlr();
    logic b;
    repeat (5) step(1'h1, ~tdi, b);
    step(1'h0, ~tdi, b);
  endtask
endmodule

// ### mbst_tap_tb.sv
// Self-checking testbench of the boundary-scan test access port.
`timescale 1ns/100ps
module mbst_tap_tb;
  logic        ref_clk, rst, tck, tms, tdi, width_36;
  logic        tdo_out, tdo_oe, mem_out_hiz, b;
  logic [69:0] pin_ring;
  logic [2:0]  instruction_select;
  int          fail_count, comparisons, cycles;
  mbst_tap mbst_tap_i (.ref_clk(ref_clk), .rst(rst), .tck(tck),
    .tms(tms), .tdi(tdi), .width_36(width_36), .pin_ring(pin_ring),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz),
    .instruction_select(instruction_select));
  mbst_tester mbst_tester_i (.ref_clk(ref_clk), .tdo_out(tdo_out),
    .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
  initial ref_clk = 1'h0;
  always #50 ref_clk = ~ref_clk;
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic t_ident(input logic w);
    logic [69:0] q;
    logic [2:0]  wexp;
    wexp = w ? mbst_pkg::ID_WIDTH_36 : mbst_pkg::ID_WIDTH_18;
    width_36 = w;
    mbst_tester_i.shift_dr(32, {35{2'h2}}, q);
    check(q[31:29], mbst_pkg::ID_REVISION);
    check(q[11:1], mbst_pkg::ID_VENDOR);
    check(q[0], 1'h1);
    check(q[17:15], wexp);
    check(q[14:12], mbst_pkg::ID_DENSITY);
    check(q[20:18], mbst_pkg::ID_MEMTYPE);
    check(q[28:21], {mbst_pkg::ID_VOLTAGE[1], mbst_pkg::ID_DEPT,
      mbst_pkg::ID_VOLTAGE[0], mbst_pkg::ID_ARCH});
    check(mem_out_hiz, 1'h0);
  endtask
  task automatic t_ir(input logic [2:0] c);
    logic [2:0] was;
    logic [2:0] cap;
    was = instruction_select;
    mbst_tester_i.shift_ir(c, cap);
    check(cap, {1'h0, mbst_pkg::IR_CAPTURE});
    check(instruction_select, was);
    mbst_tester_i.update();
    check(instruction_select, c);
    check(mem_out_hiz, c == 3'h0 || c == 3'h2);
  endtask
  task automatic t_chain(input logic [2:0] c, input logic [69:0] p);
    logic [69:0] q;
    t_ir(c);
    pin_ring = p;
    mbst_tester_i.shift_dr(70, ~p, q);
    check(q, p);
    check(mem_out_hiz, c != mbst_pkg::INS_SAMPLE);
  endtask
  task automatic t_bypass();
    logic [69:0] q;
    t_ir(mbst_pkg::INS_BYPASS);
    mbst_tester_i.shift_dr(8, 70'hB4, q);
    check(q, 70'h68);
  endtask
  task automatic t_tlr();
    mbst_tester_i.tlr();
    check(instruction_select, mbst_pkg::IR_RESET);
    check(tdo_oe, 1'h0);
  endtask
  initial begin
    rst = 1'h1;
    width_36 = 1'h1;
    pin_ring = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    check(instruction_select, mbst_pkg::IR_RESET);
    mbst_tester_i.step(1'h0, 1'h1, b);
    t_ident(1'h1);
    t_ident(1'h0);
    t_chain(mbst_pkg::INS_EXTEST, 70'h2A_F0F0_1234_5678_9ABC);
    t_chain(mbst_pkg::INS_SAMPZ, 70'h1_5555_AAAA_0F0F_3C3C);
    t_chain(mbst_pkg::INS_SAMPLE, 70'h3F_0000_FFFF_8001_7E7E);
    t_bypass();
    t_ir(mbst_pkg::INS_IDCODE);
    t_ident(1'h1);
    t_ir(mbst_pkg::INS_EXTEST);
    t_tlr();
    finish_test();
  end
endmodule
